// *** logic/clkgen_pkg.sv ***
// constants shared by the clock generator: register map, fields, reset values
package clkgen_pkg;
  localparam int          NUM_REGS     = 9;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_PRI_CFG  = 8'h04;
  localparam logic [7:0]  OFF_SEC_CFG  = 8'h08;
  localparam logic [7:0]  OFF_SYSDIV   = 8'h0c;
  localparam logic [7:0]  OFF_PRI_BYP  = 8'h10;
  localparam logic [7:0]  OFF_OBS_DIV  = 8'h14;
  localparam logic [7:0]  OFF_SEC_OUT  = 8'h18;
  localparam logic [7:0]  OFF_SEC_BYP  = 8'h1c;
  localparam logic [7:0]  OFF_STATUS   = 8'h20;
  // register indices (byte offset / 4)
  localparam int          IDX_CTRL     = 0;
  localparam int          IDX_PRI_CFG  = 1;
  localparam int          IDX_SEC_CFG  = 2;
  localparam int          IDX_SYSDIV   = 3;
  localparam int          IDX_PRI_BYP  = 4;
  localparam int          IDX_OBS_DIV  = 5;
  localparam int          IDX_SEC_OUT  = 6;
  localparam int          IDX_SEC_BYP  = 7;
  localparam int          IDX_STATUS   = 8;
  // control fields
  localparam int          CTRL_NEWER   = 0;
  localparam int          CTRL_PRI_EN  = 1;
  localparam int          CTRL_SEC_EN  = 2;
  localparam int          CTRL_USB_EN  = 3;
  // field positions
  localparam int          MULT_LSB     = 0;
  localparam int          POST_LSB     = 8;
  localparam int          DIV_A_LSB    = 0;
  localparam int          DIV_B_LSB    = 8;
  localparam int          DIV_C_LSB    = 16;
  localparam int          STAT_PRI_LK  = 0;
  localparam int          STAT_SEC_LK  = 1;
  localparam int          STAT_USB_LK  = 2;
  localparam int          STAT_PER_LSB = 16;
  // reset values; divider fields hold ratio minus one
  localparam logic [31:0] RST_CTRL     = 32'h0000000f;
  localparam logic [31:0] RST_PRI_CFG  = 32'h00000001;
  localparam logic [31:0] RST_SEC_CFG  = 32'h00000001;
  localparam logic [31:0] RST_SYSDIV   = 32'h00050200;
  localparam logic [31:0] RST_PRI_BYP  = 32'h00000000;
  localparam logic [31:0] RST_OBS_DIV  = 32'h00000000;
  localparam logic [31:0] RST_SEC_OUT  = 32'h00000901;
  localparam logic [31:0] RST_SEC_BYP  = 32'h00000001;
  // writable bits
  localparam logic [31:0] WM_CTRL      = 32'h0000000f;
  localparam logic [31:0] WM_CFG       = 32'h0000033f;
  localparam logic [31:0] WM_MULT      = 32'h0000003f;
  localparam logic [31:0] WM_SYSDIV    = 32'h001f1f1f;
  localparam logic [31:0] WM_DIV1      = 32'h0000001f;
  localparam logic [31:0] WM_DIV2      = 32'h00001f1f;
  // legacy fixed system divider and post-divider limits (ratio minus one)
  localparam logic [4:0]  LIM_DIV2     = 5'h01;
  localparam logic [4:0]  LIM_DIV3     = 5'h02;
  localparam logic [4:0]  LIM_DIV6     = 5'h05;
  localparam logic [4:0]  LIM_POST_MAX = 5'h02;
  // usb loop multiplies by five halves
  localparam logic [5:0]  USB_NUM      = 6'h05;
  localparam int          USB_DEN      = 2;
  localparam logic [15:0] PERIOD_RST   = 16'h0000;
endpackage

// *** logic/clkgen.sv ***
// clock generator: reference period tracker, three synthesized loops, dividers, wishbone regs
// How it works
// R01: legacy primary loop multiplies reference, then post-divides by one, two or three.
// R02: legacy derives five system clocks from post-divided primary: ratios 1,2,3,4,6.
// R03: legacy divide-by-four system clock is reserved and drives nothing.
// R04: legacy primary bypass divides raw reference 1..32 onto observed clock output.
// R05: legacy secondary loop multiplies reference, feeds two output dividers 1..16.
// R06: legacy secondary outputs clock video processing subsystem and DDR2 interface.
// R07: secondary bypass divides raw reference 1..32 for impedance calibration, both variants.
// R08: legacy usb loop multiplies its reference by 2.5 for the USB clock.
// R09: newer variant has only two loops, no usb loop.
// R10: newer primary feeds three system dividers 1..32, no post-divider.
// R11: newer system clocks drive core, DMA and video front end.
// R12: software keeps newer system clock frequencies at 1:3:6.
// R13: newer primary bypass divides raw reference 1..32 for video back end.
// R14: newer separate bypass divider 1..32 produces observed clock output.
// R15: newer secondary feeds two dividers 1..32 for DDR2 and video.
// R16: newer observed and primary bypass reset to one, secondary bypass to two.
// R17: new divider ratio takes effect only at an output period boundary.
// R18: bypass dividers run from reference regardless of loop enable or lock.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ns

// ----------------------------------------------------------------
// tick divider: one output tick every (limit+1) input ticks
// ----------------------------------------------------------------
module tick_divider #(
  parameter logic [4:0] RESET_LIM = 5'h00
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       tick_in,
  input  wire logic [4:0] limit,
  output logic            tick_out
);
  logic [4:0] cnt_q;
  logic [4:0] lim_q;
  wire        wrap = (cnt_q >= lim_q);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_q    <= 5'h00;
      lim_q    <= RESET_LIM;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in & wrap;
      if (tick_in) begin
        // limit is taken only at wrap, so a rewrite never cuts a period short
        if (wrap) begin
          cnt_q <= 5'h00;
          lim_q <= limit; // R17
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// synthesized loop: tick rate = num/den times the reference rate
// ----------------------------------------------------------------
module tick_loop #(
  parameter int DEN = 1
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        enable,
  input  wire logic        ref_tick,
  input  wire logic        period_ok,
  input  wire logic [15:0] period,
  input  wire logic [5:0]  num,
  output logic             tick,
  output logic             locked
);
  // den is 1 or 2 here, so two bits hold it
  localparam logic [1:0] DEN_W = 2'(DEN);
  logic [19:0] acc_q;
  wire  [19:0] modulus = 20'(period) * 20'(DEN_W);
  wire  [19:0] sum     = acc_q + 20'(num);
  wire         over    = (sum >= modulus);
  wire  [19:0] wrap_sum = (sum >= 20'(modulus << 1)) ? 20'h00000 : sum - modulus;
  wire  [19:0] acc_d    = !locked ? 20'h00000 : (over ? wrap_sum : sum);

  // limitation: products above the CLK rate saturate at one tick per cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      acc_q  <= 20'h00000;
      tick   <= 1'b0;
      locked <= 1'b0;
    end else if (!enable || !period_ok) begin
      acc_q  <= 20'h00000;
      tick   <= 1'b0;
      locked <= 1'b0;
    end else begin
      if (ref_tick) begin
        locked <= 1'b1;
      end
      tick  <= locked & over;
      acc_q <= acc_d;
    end
  end
endmodule

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module clkgen
  import clkgen_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        REF_IN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             CORE_EN,
  output logic             HALF_EN,
  output logic             DMA_EN,
  output logic             LOW_RATE_EN,
  output logic             VIDEO_PROCESSING_SUBSYSTEM_EN,
  output logic             DDR_EN,
  output logic             VIDEO_BACK_END_EN,
  output logic             OBSERVED_CLOCK_OUT,
  output logic             IMPEDANCE_CALIBRATION_EN,
  output logic             USB_EN
);
  import clkgen_pkg::*;

  // ----------------------------------------------------------------
  // reference synchronizer and period measurement
  // ----------------------------------------------------------------
  logic        ref_s1_q;
  logic        ref_s2_q;
  logic        ref_s3_q;
  logic [15:0] run_q;
  logic [15:0] period_q;
  logic [1:0]  seen_q;
  wire         ref_tick  = ref_s2_q & ~ref_s3_q;
  // first period after reset is partial, and a pin high at release gives a false edge
  wire         period_ok = &seen_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      run_q    <= PERIOD_RST;
      period_q <= PERIOD_RST;
      seen_q   <= 2'h0;
    end else begin
      ref_s1_q <= REF_IN;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      // run_q saturates, but after a stopped reference period_q = run_q + 1 wraps to zero
      if (ref_tick) begin
        run_q    <= PERIOD_RST;
        period_q <= run_q + 16'h0001;
        if (seen_q != 2'h3) begin
          seen_q <= seen_q + 2'h1;
        end
      end else if (run_q != 16'hffff) begin
        run_q <= run_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] regs_q [NUM_REGS-1];
  logic [31:0] rdata;
  wire  [31:0] bmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire         req   = WB_CYC_I & WB_STB_I;
  wire         ack_d = req & ~WB_ACK_O;
  // a write lands at the edge where the master sees ack high
  wire         wr_go = req & WB_WE_I & WB_ACK_O;
  // word addressed, byte lanes written per WB_SEL_I: the two low address bits are ignored
  wire  [5:0]  index = WB_ADR_I[7:2];
  wire         pri_lk;
  wire         sec_lk;
  wire         usb_lk;
  wire  [31:0] status = {period_q, 13'h0000, usb_lk, sec_lk, pri_lk};

  localparam logic [31:0] RST_VAL [NUM_REGS-1] = '{RST_CTRL, RST_PRI_CFG, RST_SEC_CFG,
    RST_SYSDIV, RST_PRI_BYP, RST_OBS_DIV, RST_SEC_OUT, RST_SEC_BYP};
  localparam logic [31:0] WMASK [NUM_REGS-1] = '{WM_CTRL, WM_CFG, WM_MULT, WM_SYSDIV,
    WM_DIV1, WM_DIV1, WM_DIV2, WM_DIV1};

  // unmapped words read zero and ignore writes, but are still acknowledged
  assign rdata = (index == 6'(IDX_STATUS)) ? status :
                 (index < 6'(IDX_STATUS)) ? regs_q[3'(index)] : 32'h00000000;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NUM_REGS - 1; i++) begin
        regs_q[i] <= RST_VAL[i]; // R16
      end
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= ack_d;
      if (ack_d) begin
        WB_DAT_O <= rdata;
      end
      for (int i = 0; i < NUM_REGS - 1; i++) begin
        if (wr_go && index == 6'(i)) begin
          regs_q[i] <= ((regs_q[i] & ~bmask) | (WB_DAT_I & bmask)) & WMASK[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire       newer   = regs_q[IDX_CTRL][CTRL_NEWER];
  wire       pri_en  = regs_q[IDX_CTRL][CTRL_PRI_EN];
  wire       sec_en  = regs_q[IDX_CTRL][CTRL_SEC_EN];
  wire       usb_en  = regs_q[IDX_CTRL][CTRL_USB_EN] & ~newer; // R09
  wire [5:0] pri_mul = regs_q[IDX_PRI_CFG][MULT_LSB +: 6];
  wire [1:0] post_f  = regs_q[IDX_PRI_CFG][POST_LSB +: 2];
  // post-divider code 3 is held at divide by three
  wire [4:0] post_l  = (5'(post_f) > LIM_POST_MAX) ? LIM_POST_MAX : 5'(post_f); // R01
  wire [5:0] sec_mul = regs_q[IDX_SEC_CFG][MULT_LSB +: 6];
  wire [4:0] sys_a   = regs_q[IDX_SYSDIV][DIV_A_LSB +: 5];
  wire [4:0] sys_b   = regs_q[IDX_SYSDIV][DIV_B_LSB +: 5];
  wire [4:0] sys_c   = regs_q[IDX_SYSDIV][DIV_C_LSB +: 5];
  wire [4:0] out_a   = regs_q[IDX_SEC_OUT][DIV_A_LSB +: 5];
  wire [4:0] out_b   = regs_q[IDX_SEC_OUT][DIV_B_LSB +: 5];
  // legacy secondary outputs are limited to 1..16
  wire [4:0] sec_la  = newer ? out_a : {1'b0, out_a[3:0]}; // R05
  wire [4:0] sec_lb  = newer ? out_b : {1'b0, out_b[3:0]}; // R15

  // ----------------------------------------------------------------
  // loops
  // ----------------------------------------------------------------
  wire pri_tick;
  wire sec_tick;
  wire usb_tick;
  wire post_tick;
  wire pri_src;

  // lock only means a period was measured; no phase tracking stands behind it
  tick_loop #(.DEN(1)) u_primary_loop (
    .CLK(CLK), .RST(RST), .enable(pri_en), .ref_tick(ref_tick), .period_ok(period_ok),
    .period(period_q), .num(pri_mul), .tick(pri_tick), .locked(pri_lk)
  );
  tick_loop #(.DEN(1)) u_secondary_loop (
    .CLK(CLK), .RST(RST), .enable(sec_en), .ref_tick(ref_tick), .period_ok(period_ok),
    .period(period_q), .num(sec_mul), .tick(sec_tick), .locked(sec_lk)
  );
  tick_loop #(.DEN(USB_DEN)) u_usb_loop ( // R08
    .CLK(CLK), .RST(RST), .enable(usb_en), .ref_tick(ref_tick), .period_ok(period_ok),
    .period(period_q), .num(USB_NUM), .tick(usb_tick), .locked(usb_lk)
  );

  // post-divider runs in both variants; only its use depends on the variant
  tick_divider u_post (
    .CLK(CLK), .RST(RST), .tick_in(pri_tick), .limit(post_l), .tick_out(post_tick)
  );
  // newer variant skips the post-divider stage
  assign pri_src = newer ? pri_tick : post_tick; // R10

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  wire sa_t;
  wire sb_t;
  wire sc_t;
  wire d2_t;
  wire d3_t;
  wire d6_t;
  wire pb_t;
  wire ob_t;
  wire oa_t;
  wire obb_t;
  wire cal_t;

  // newer system dividers; software keeps them at 1:3:6 (R12)
  tick_divider #(.RESET_LIM(5'h00)) u_sys_a (
    .CLK(CLK), .RST(RST), .tick_in(pri_src), .limit(sys_a), .tick_out(sa_t)); // R10
  tick_divider #(.RESET_LIM(5'h02)) u_sys_b (
    .CLK(CLK), .RST(RST), .tick_in(pri_src), .limit(sys_b), .tick_out(sb_t));
  tick_divider #(.RESET_LIM(5'h05)) u_sys_c (
    .CLK(CLK), .RST(RST), .tick_in(pri_src), .limit(sys_c), .tick_out(sc_t));
  // legacy fixed ratios; the divide-by-four path is reserved and not built
  tick_divider #(.RESET_LIM(LIM_DIV2)) u_fix2 (
    .CLK(CLK), .RST(RST), .tick_in(pri_src), .limit(LIM_DIV2), .tick_out(d2_t)); // R02 R03
  tick_divider #(.RESET_LIM(LIM_DIV3)) u_fix3 (
    .CLK(CLK), .RST(RST), .tick_in(pri_src), .limit(LIM_DIV3), .tick_out(d3_t));
  tick_divider #(.RESET_LIM(LIM_DIV6)) u_fix6 (
    .CLK(CLK), .RST(RST), .tick_in(pri_src), .limit(LIM_DIV6), .tick_out(d6_t));
  // bypass dividers run from the raw reference, never gated by loop state
  tick_divider #(.RESET_LIM(5'h00)) u_pri_byp (
    .CLK(CLK), .RST(RST), .tick_in(ref_tick), .limit(regs_q[IDX_PRI_BYP][4:0]),
    .tick_out(pb_t)); // R04 R13 R18
  tick_divider #(.RESET_LIM(5'h00)) u_obs (
    .CLK(CLK), .RST(RST), .tick_in(ref_tick), .limit(regs_q[IDX_OBS_DIV][4:0]),
    .tick_out(ob_t)); // R14 R18
  tick_divider #(.RESET_LIM(5'h01)) u_sec_byp (
    .CLK(CLK), .RST(RST), .tick_in(ref_tick), .limit(regs_q[IDX_SEC_BYP][4:0]),
    .tick_out(cal_t)); // R07 R18
  tick_divider #(.RESET_LIM(5'h01)) u_sec_a (
    .CLK(CLK), .RST(RST), .tick_in(sec_tick), .limit(sec_la), .tick_out(oa_t));
  tick_divider #(.RESET_LIM(5'h09)) u_sec_b (
    .CLK(CLK), .RST(RST), .tick_in(sec_tick), .limit(sec_lb), .tick_out(obb_t));

  // ----------------------------------------------------------------
  // destination routing per variant
  // ----------------------------------------------------------------
  // outputs are one-cycle enables, not clocks, so every consumer stays on CLK
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CORE_EN                       <= 1'b0;
      HALF_EN                       <= 1'b0;
      DMA_EN                        <= 1'b0;
      LOW_RATE_EN                   <= 1'b0;
      VIDEO_PROCESSING_SUBSYSTEM_EN <= 1'b0;
      DDR_EN                        <= 1'b0;
      VIDEO_BACK_END_EN             <= 1'b0;
      OBSERVED_CLOCK_OUT            <= 1'b0;
      IMPEDANCE_CALIBRATION_EN      <= 1'b0;
      USB_EN                        <= 1'b0;
    end else begin
      CORE_EN                       <= newer ? sa_t : pri_src; // R02 R11
      HALF_EN                       <= ~newer & d2_t;
      DMA_EN                        <= newer ? sb_t : d3_t; // R11
      LOW_RATE_EN                   <= newer ? sc_t : d6_t; // R11
      VIDEO_PROCESSING_SUBSYSTEM_EN <= obb_t; // R06 R15
      DDR_EN                        <= oa_t; // R06 R15
      VIDEO_BACK_END_EN             <= newer & pb_t; // R13
      OBSERVED_CLOCK_OUT            <= newer ? ob_t : pb_t; // R04 R14
      IMPEDANCE_CALIBRATION_EN      <= cal_t; // R07
      USB_EN                        <= usb_tick; // R08
    end
  end
endmodule

// *** bench/clkgen_props.sv ***
// checker: bus handshake and clock-enable pulse relations of the clock generator
`timescale 1ns/1ns
module clkgen_props (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        REF_IN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic        WB_ACK_O,
  input  wire logic        CORE_EN,
  input  wire logic        HALF_EN,
  input  wire logic        VIDEO_BACK_END_EN,
  input  wire logic        OBSERVED_CLOCK_OUT,
  input  wire logic        IMPEDANCE_CALIBRATION_EN,
  input  wire logic        USB_EN
);
  logic       newer_q;
  logic       ref_q;
  logic [3:0] since_q;
  wire        ctrl_wr = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0]
                        && (WB_ADR_I[7:2] == 6'h00);
  wire        ref_rise = REF_IN && !ref_q;
  // shadow of the variant bit; cycles since the raw reference rose
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      newer_q <= 1'b1;
      ref_q   <= 1'b0;
      since_q <= 4'hf;
    end else begin
      ref_q   <= REF_IN;
      since_q <= ref_rise ? 4'h0 : ((since_q == 4'hf) ? 4'hf : since_q + 4'h1);
      if (ctrl_wr) newer_q <= WB_DAT_I[0];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_ack_resp;   WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  property p_ack_one;    WB_ACK_O |=> !WB_ACK_O; endproperty
  property p_quiet;      $past(RST) |-> !(CORE_EN || OBSERVED_CLOCK_OUT || USB_EN); endproperty
  property p_obs_ref;    OBSERVED_CLOCK_OUT |-> since_q inside {[2:8]}; endproperty
  property p_vtp_ref;    IMPEDANCE_CALIBRATION_EN |-> since_q inside {[2:8]}; endproperty
  property p_obs_single; OBSERVED_CLOCK_OUT |=> !OBSERVED_CLOCK_OUT [*2]; endproperty
  property p_vbe_legacy; !newer_q && !$past(newer_q, 6) |-> !VIDEO_BACK_END_EN; endproperty
  property p_newer_quiet; newer_q && $past(newer_q, 6) |-> !HALF_EN && !USB_EN; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  a_quiet: assert property (p_quiet) else $error("enable pulse right after reset");
  a_obs_ref: assert property (p_obs_ref) else $error("observed pulse off reference");
  a_vtp_ref: assert property (p_vtp_ref) else $error("calibration pulse off ref");
  a_obs_single: assert property (p_obs_single) else $error("observed pulse too long");
  a_vbe_legacy: assert property (p_vbe_legacy) else $error("back end clock in legacy");
  a_newer_quiet: assert property (p_newer_quiet) else $error("legacy clock in newer");
  c_usb: cover property (USB_EN);
  c_vbe: cover property (VIDEO_BACK_END_EN);
  c_half: cover property (HALF_EN && CORE_EN);
endmodule

// *** bench/clock_domains.sv ***
// partner: reference oscillator and the consumer domains counting enable pulses
`timescale 1ns/1ns
module clock_domains #(
  parameter int HALF = 8
) (
  input  wire logic       CLK,
  input  wire logic       clr,
  input  wire logic       count_on,
  input  wire logic [9:0] en_vec,
  output logic            ref_out,
  output int              cnt [10]
);
  int ph = 0;
  initial ref_out = 1'b0;
  // oscillator runs free, reset or not; changes right after the edge
  always @(posedge CLK) begin
    ph <= (ph == HALF - 1) ? 0 : ph + 1;
    if (ph == HALF - 1) ref_out <= !ref_out;
    for (int i = 0; i < 10; i++) begin
      if (clr) cnt[i] <= 0;
      else if (count_on && en_vec[i]) cnt[i] <= cnt[i] + 1;
    end
  end
endmodule

// *** bench/tb_top.sv ***
// testbench: register map, divider rates in both variants, bypass independence
`timescale 1ns/1ns
module tb_top;
  import clkgen_pkg::*;
  localparam int TICKS = 96;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b0, con = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wd = 32'h0, rdat, x, r = 32'h65e0e1cd;
  logic        ack, ref_in;
  logic [9:0]  ev;
  int          cnt [10];
  int          miscompares = 0, n_checks = 0, a, o, v, d, p, s;
  initial forever #5 clk = !clk;
  clkgen u_clkgen (.CLK(clk), .RST(rst), .REF_IN(ref_in), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .CORE_EN(ev[0]), .HALF_EN(ev[1]), .DMA_EN(ev[2]), .LOW_RATE_EN(ev[3]),
    .VIDEO_PROCESSING_SUBSYSTEM_EN(ev[4]), .DDR_EN(ev[5]), .VIDEO_BACK_END_EN(ev[6]),
    .OBSERVED_CLOCK_OUT(ev[7]), .IMPEDANCE_CALIBRATION_EN(ev[8]), .USB_EN(ev[9]));
  clock_domains u_clock_domains (.CLK(clk), .clr(clr), .count_on(con), .en_vec(ev),
    .ref_out(ref_in), .cnt(cnt));
  function automatic logic [31:0] lfsr(input logic [31:0] q);
    return {q[30:0], q[31] ^ q[21] ^ q[1] ^ q[0]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic err(input string m);
    miscompares++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  // classic cycle: hold until ack sampled high, take data there, then release
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt,
                    input logic [3:0] sl, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; wd <= dt; sel <= sl;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err("ack timeout");
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    wb(1'b1, ad, dt, 4'hf, x);
  endtask
  task automatic chk(input logic [7:0] ad, input logic [31:0] exp);
    wb(1'b0, ad, 32'h0, 4'hf, x);
    n_checks++;
    if (x !== exp) err($sformatf("reg %h got %h exp %h", ad, x, exp));
  endtask
  // pulse counts over a fixed number of reference periods, one off allowed at edges
  task automatic measure(input string nm, input int e [10]);
    @(posedge clk); clr <= 1'b1;
    @(posedge clk); clr <= 1'b0; con <= 1'b1;
    repeat (TICKS * 16) @(posedge clk);
    con <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      n_checks++;
      if (cnt[i] > e[i] + 1 || cnt[i] + 1 < e[i])
        err($sformatf("%s out %0d got %0d exp %0d", nm, i, cnt[i], e[i]));
    end
    $display("test %s done", nm);
  endtask
  initial begin
    logic [31:0] rv [8];
    rv = '{RST_CTRL, RST_PRI_CFG, RST_SEC_CFG, RST_SYSDIV, RST_PRI_BYP, RST_OBS_DIV,
           RST_SEC_OUT, RST_SEC_BYP};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) chk(8'(i * 4), rv[i]);
    wr(8'h24, 32'hffffffff);
    chk(8'h24, 32'h0);
    wb(1'b1, OFF_OBS_DIV, 32'h1f, 4'h0, x);
    chk(OFF_OBS_DIV, 32'h0);
    $display("test regs done");
    repeat (100) @(posedge clk);
    chk(OFF_STATUS, {16'd16, 13'h0000, 3'b011});
    measure("newer", '{96, 0, 32, 16, 9, 48, 96, 96, 48, 0});
    for (int k = 0; k < 3; k++) begin
      repeat (5) r = lfsr(r);
      a = r % 5; o = r[12:8]; v = r[20:16]; d = r[28:24]; p = r[7:3]; s = r[17:13];
      wr(OFF_SYSDIV, {11'h0, 5'(6 * a + 5), 3'h0, 5'(3 * a + 2), 3'h0, 5'(a)});
      wr(OFF_OBS_DIV, 32'(o));
      wr(OFF_PRI_BYP, 32'(v));
      wr(OFF_SEC_OUT, {19'h0, 5'(p), 3'h0, 5'(d)});
      wr(OFF_SEC_BYP, 32'(s));
      repeat (600) @(posedge clk);
      measure("random", '{96 / (a + 1), 0, 32 / (a + 1), 16 / (a + 1), 96 / (p + 1),
              96 / (d + 1), 96 / (v + 1), 96 / (o + 1), 96 / (s + 1), 0});
    end
    wr(OFF_CTRL, 32'he);
    wr(OFF_PRI_CFG, 32'h101);
    wr(OFF_PRI_BYP, 32'h3);
    wr(OFF_SEC_OUT, 32'hf13);
    wr(OFF_SEC_BYP, 32'h0);
    repeat (600) @(posedge clk);
    measure("legacy", '{48, 24, 16, 8, 6, 24, 0, 24, 96, 240});
    wr(OFF_CTRL, 32'h1);
    repeat (600) @(posedge clk);
    measure("bypass", '{0, 0, 0, 0, 0, 0, 24, 96 / (o + 1), 96, 0});
    report_and_stop();
  end
  initial begin
    #300000;
    err("watchdog");
    report_and_stop();
  end
endmodule
bind clkgen clkgen_props u_clkgen_props (.CLK(CLK), .RST(RST), .REF_IN(REF_IN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .CORE_EN(CORE_EN),
  .HALF_EN(HALF_EN),
  .VIDEO_BACK_END_EN(VIDEO_BACK_END_EN), .OBSERVED_CLOCK_OUT(OBSERVED_CLOCK_OUT),
  .IMPEDANCE_CALIBRATION_EN(IMPEDANCE_CALIBRATION_EN), .USB_EN(USB_EN));
